//--- shared/csb_pkg.sv
// constants for the processor sideband control block
package csb_pkg;
  // register byte offsets on the bus slave
  localparam logic [7:0]  CSB_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  CSB_OFS_EVENT  = 8'h04;
  localparam logic [7:0]  CSB_OFS_STATUS = 8'h08;
  localparam logic [7:0]  CSB_OFS_VECTOR = 8'h0C;
  // control register fields
  localparam int unsigned CSB_CTRL_W       = 4;
  localparam int unsigned CSB_CTRL_NREP    = 0;
  localparam int unsigned CSB_CTRL_LIC_EN  = 1;
  localparam int unsigned CSB_CTRL_ATOMIC  = 2;
  localparam int unsigned CSB_CTRL_DBG_RDY = 3;
  localparam logic [3:0]  CSB_CTRL_RST     = 4'h2;
  // event register fields, write one to fire
  localparam int unsigned CSB_EV_W       = 3;
  localparam int unsigned CSB_EV_FAULT   = 0;
  localparam int unsigned CSB_EV_FP_ERR  = 1;
  localparam int unsigned CSB_EV_FP_INSN = 2;
  // status register width
  localparam int unsigned CSB_STAT_W = 12;
  // synchronised pin indices
  localparam int unsigned CSB_NSYNC    = 7;
  localparam int unsigned CSB_SI_BRST  = 0;
  localparam int unsigned CSB_SI_INIT  = 1;
  localparam int unsigned CSB_SI_IGN   = 2;
  localparam int unsigned CSB_SI_LIRQ0 = 3;
  localparam int unsigned CSB_SI_LIRQ1 = 4;
  localparam int unsigned CSB_SI_DREQ  = 5;
  localparam int unsigned CSB_SI_STPC  = 6;
  localparam logic [6:0]  CSB_SYNC_RST = 7'h7F;
  localparam int unsigned CSB_NIRQ     = 2;
  // bus constants
  localparam logic [2:0]  CSB_HSIZE_WORD = 3'h2;
  localparam logic [31:0] CSB_VEC_RST    = 32'h0000_0000;
endpackage

//--- design/csb_sideband.sv
// processor sideband control pins with an AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csb_sideband (
  // clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_nrst,
  // ahb-lite slave
  input  wire logic                         i_hsel,
  input  wire logic [31:0]                  i_haddr,
  input  wire logic [1:0]                   i_htrans,
  input  wire logic                         i_hwrite,
  input  wire logic [2:0]                   i_hsize,
  input  wire logic                         i_hready,
  input  wire logic [31:0]                  i_hwdata,
  output logic [31:0]                       o_hrdata,
  output logic                              o_hreadyout,
  output logic                              o_hresp,
  // sideband pins, active low
  input  wire logic                         i_bus_restart_in_n,
  input  wire logic                         i_soft_restart_in_n,
  input  wire logic                         i_ignore_numeric_error_in_n,
  input  wire logic [csb_pkg::CSB_NIRQ-1:0] i_local_irq_lines_n,
  input  wire logic                         i_debug_request_in_n,
  input  wire logic                         i_clock_stop_request_n,
  output logic                              o_internal_fault_out_n,
  output logic                              o_fp_error_break_event_out_n,
  output logic                              o_debug_ready_out_n,
  output logic                              o_atomic_seq_n,
  // system bus side
  input  wire logic                         i_bus_txn_start,
  input  wire logic                         i_bus_txn_end,
  input  wire logic                         i_snoop_req,
  output logic                              o_snoop_ack,
  output logic                              o_shutdown_txn,
  // core side
  input  wire logic [31:0]                  i_cfg_reset_vector,
  output logic                              o_int_regs_reset,
  output logic                              o_resume_fetch,
  output logic [31:0]                       o_fetch_addr,
  output logic                              o_bist_start,
  output logic                              o_fp_exception,
  output logic                              o_maskable_irq_req,
  output logic                              o_nmi_req,
  output logic [csb_pkg::CSB_NIRQ-1:0]      o_local_irq
);
  import csb_pkg::*;

  // pin synchronisers, reset to the deasserted (high) level
  wire logic [CSB_NSYNC-1:0] raw_n = {i_clock_stop_request_n, i_debug_request_in_n,
                                      i_local_irq_lines_n[1], i_local_irq_lines_n[0],
                                      i_ignore_numeric_error_in_n, i_soft_restart_in_n,
                                      i_bus_restart_in_n};
  logic [CSB_NSYNC-1:0] sync1_q;
  logic [CSB_NSYNC-1:0] sync2_q;

  for (genvar k = 0; k < CSB_NSYNC; k++) begin : g_sync
    always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
        sync1_q[k] <= CSB_SYNC_RST[k];
        sync2_q[k] <= CSB_SYNC_RST[k];
      end else begin
        sync1_q[k] <= raw_n[k];
        sync2_q[k] <= sync1_q[k];
      end
    end
  end

  // asserted levels; low on the pin means active
  wire logic brst_a  = ~sync2_q[CSB_SI_BRST];
  wire logic init_a  = ~sync2_q[CSB_SI_INIT];
  wire logic ign_a   = ~sync2_q[CSB_SI_IGN];
  wire logic lirq0_a = ~sync2_q[CSB_SI_LIRQ0];
  wire logic lirq1_a = ~sync2_q[CSB_SI_LIRQ1];
  wire logic dreq_a  = ~sync2_q[CSB_SI_DREQ];
  wire logic stpc_a  = ~sync2_q[CSB_SI_STPC];

  // ahb-lite address phase; only whole-word transfers are taken
  wire logic ahb_acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == CSB_HSIZE_WORD);
  logic       ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q   <= ahb_acc & i_hwrite;
      ap_addr_q <= i_haddr[7:0];
    end
  end

  wire logic wr_ctrl  = ap_wr_q & (ap_addr_q == CSB_OFS_CTRL);
  wire logic wr_event = ap_wr_q & (ap_addr_q == CSB_OFS_EVENT);
  wire logic [CSB_EV_W-1:0] ev = wr_event ? i_hwdata[CSB_EV_W-1:0] : '0;

  // control state
  logic [CSB_CTRL_W-1:0] ctrl_q;
  logic fault_q, shutdown_q, fp_pend_q, fp_exc_q, break_q, fpbe_q;
  logic init_prev_q, int_rst_q, resume_q, rst_seen_q, bist_q, bist_ran_q;
  logic snoop_q, lock_q, mirq_q, nmi_q;
  logic [CSB_NIRQ-1:0] lirq_q;
  logic [31:0] vec_q, fetch_q;

  wire logic nrep_bit = ctrl_q[CSB_CTRL_NREP];
  wire logic lic_en   = ctrl_q[CSB_CTRL_LIC_EN];
  wire logic atomic_c = ctrl_q[CSB_CTRL_ATOMIC];

  // fault: set wins over any clear arriving in the same cycle
  wire logic fault_d = ev[CSB_EV_FAULT] | (fault_q & ~(brst_a | init_a));
  // with the report bit set the ignore pin is not looked at
  wire logic take_exc = ev[CSB_EV_FP_INSN] & fp_pend_q & (nrep_bit | ~ign_a);
  wire logic fp_pend_d = ev[CSB_EV_FP_ERR] | (fp_pend_q & ~take_exc);
  // break event holds until clock stop drops
  wire logic break_d = stpc_a & (dreq_a | break_q);
  // pins qualified by the system at target ready, so no extra qualifier here
  wire logic init_rise = init_a & ~init_prev_q;
  wire logic init_fall = ~init_a & init_prev_q;

  wire logic [CSB_STAT_W-1:0] status = {lock_q, dreq_a, lirq1_a, lirq0_a, stpc_a, break_q,
                                        init_a, bist_ran_q, ign_a, fp_pend_q, shutdown_q,
                                        fault_q};
  wire logic [31:0] rd_mux =
    (i_haddr[7:0] == CSB_OFS_CTRL)   ? {{(32-CSB_CTRL_W){1'b0}}, ctrl_q} :
    (i_haddr[7:0] == CSB_OFS_STATUS) ? {{(32-CSB_STAT_W){1'b0}}, status} :
    (i_haddr[7:0] == CSB_OFS_VECTOR) ? vec_q : 32'h0000_0000;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      hrdata_q <= 32'h0000_0000;
      ctrl_q   <= CSB_CTRL_RST;
    end else begin
      hrdata_q <= (ahb_acc & ~i_hwrite) ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_q <= i_hwdata[CSB_CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      fault_q    <= 1'b0;
      shutdown_q <= 1'b0;
      fp_pend_q  <= 1'b0;
      fp_exc_q   <= 1'b0;
      break_q    <= 1'b0;
      fpbe_q     <= 1'b0;
    end else begin
      fault_q    <= fault_d;
      shutdown_q <= ev[CSB_EV_FAULT] & ~fault_q;
      fp_pend_q  <= fp_pend_d;
      fp_exc_q   <= take_exc;
      break_q    <= break_d;
      fpbe_q     <= stpc_a ? break_q : fp_pend_q;
    end
  end

  // soft restart, reset-vector strap and self-test request
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      init_prev_q <= 1'b0;
      int_rst_q   <= 1'b0;
      resume_q    <= 1'b0;
      rst_seen_q  <= 1'b0;
      bist_q      <= 1'b0;
      bist_ran_q  <= 1'b0;
      vec_q       <= CSB_VEC_RST;
      fetch_q     <= CSB_VEC_RST;
    end else begin
      init_prev_q <= init_a;
      int_rst_q   <= init_rise;
      resume_q    <= init_fall;
      rst_seen_q  <= 1'b1;
      // raw pin read on the first cycle after release, before the synchroniser fills
      bist_q      <= ~rst_seen_q & ~i_soft_restart_in_n;
      bist_ran_q  <= bist_ran_q | (~rst_seen_q & ~i_soft_restart_in_n);
      if (!rst_seen_q) begin
        vec_q <= i_cfg_reset_vector;
      end
      if (init_fall) begin
        fetch_q <= vec_q;
      end
    end
  end

  // snoop, interrupts and atomic sequence
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      snoop_q <= 1'b0;
      lock_q  <= 1'b0;
      mirq_q  <= 1'b0;
      nmi_q   <= 1'b0;
      lirq_q  <= '0;
    end else begin
      // not gated by soft restart on purpose
      snoop_q <= i_snoop_req;
      mirq_q  <= ~lic_en & lirq0_a;
      nmi_q   <= ~lic_en & lirq1_a;
      lirq_q  <= lic_en ? {lirq1_a, lirq0_a} : '0;
      if (atomic_c & i_bus_txn_start) begin
        lock_q <= 1'b1;
      end else if (~atomic_c & i_bus_txn_end) begin
        lock_q <= 1'b0;
      end
    end
  end

  // outputs
  assign o_hrdata                     = hrdata_q;
  assign o_hreadyout                  = 1'b1;
  assign o_hresp                      = 1'b0;
  assign o_internal_fault_out_n       = ~fault_q;
  assign o_shutdown_txn               = shutdown_q;
  assign o_fp_error_break_event_out_n = ~fpbe_q;
  assign o_fp_exception               = fp_exc_q;
  assign o_debug_ready_out_n          = ~ctrl_q[CSB_CTRL_DBG_RDY];
  // combinational so the first transaction is covered; priority agent waits on it
  assign o_atomic_seq_n = ~(lock_q | (atomic_c & i_bus_txn_start));
  assign o_snoop_ack                  = snoop_q;
  assign o_int_regs_reset             = int_rst_q;
  assign o_resume_fetch               = resume_q;
  assign o_fetch_addr                 = fetch_q;
  assign o_bist_start                 = bist_q;
  assign o_maskable_irq_req           = mirq_q;
  assign o_nmi_req                    = nmi_q;
  assign o_local_irq                  = lirq_q;

  property p_fault_set;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      ev[CSB_EV_FAULT] |=> !o_internal_fault_out_n;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault output not raised");

  property p_shutdown;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(fault_q) |-> o_shutdown_txn ##1 !o_shutdown_txn;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown pulse missing");

  property p_fault_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (fault_q && !brst_a && !init_a) |=> !o_internal_fault_out_n;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");

  property p_ignore;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (ev[CSB_EV_FP_INSN] && fp_pend_q && !nrep_bit && ign_a) |=> !o_fp_exception && fp_pend_q;
  endproperty
  a_ignore: assert property (p_ignore) else $error("error not ignored");

  property p_exc;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (ev[CSB_EV_FP_INSN] && fp_pend_q && !ign_a) |=> o_fp_exception;
  endproperty
  a_exc: assert property (p_exc) else $error("fp exception missing");

  property p_nrep;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (ev[CSB_EV_FP_INSN] && fp_pend_q && nrep_bit) |=> o_fp_exception;
  endproperty
  a_nrep: assert property (p_nrep) else $error("ignore pin acted with report bit set");

  property p_init;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $fell(sync2_q[CSB_SI_INIT]) |=> o_int_regs_reset ##1 !o_int_regs_reset;
  endproperty
  a_init: assert property (p_init) else $error("integer reset pulse wrong");

  property p_resume;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_resume_fetch |-> (o_fetch_addr == vec_q);
  endproperty
  a_resume: assert property (p_resume) else $error("resume address wrong");

  property p_snoop;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_snoop_req && init_a) |=> o_snoop_ack;
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop dropped in soft restart");

  property p_bist;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (!rst_seen_q && !i_soft_restart_in_n) |=> o_bist_start ##1 !o_bist_start;
  endproperty
  a_bist: assert property (p_bist) else $error("self-test not started");

  property p_legacy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (!lic_en && lirq0_a && !lirq1_a) |=> o_maskable_irq_req && !o_nmi_req && (o_local_irq == '0);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy interrupt map wrong");

  property p_lic_rst;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !rst_seen_q |-> lic_en;
  endproperty
  a_lic_rst: assert property (p_lic_rst) else $error("controller not enabled at reset");

  property p_lock;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (lock_q && !(i_bus_txn_end && !atomic_c)) |=> !o_atomic_seq_n;
  endproperty
  a_lock: assert property (p_lock) else $error("atomic output dropped inside sequence");

  property p_break;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (dreq_a && stpc_a) ##1 stpc_a |=> !o_fp_error_break_event_out_n;
  endproperty
  a_break: assert property (p_break) else $error("break event not shown");
endmodule
`default_nettype wire

//--- bench/csb_chipset_model.sv
// far-side model: chipset, bus agents and debug tool on the sideband pins
`timescale 1ns/1ps
`default_nettype none
module csb_chipset_model (
  // commands from the bench, high = assert
  input  wire logic [10:0] i_cmd,
  input  wire logic        i_atomic_seq_n,
  // pins toward the block
  output logic             o_bus_restart_n,
  output logic             o_soft_restart_n,
  output logic             o_ignore_n,
  output logic [1:0]       o_lirq_n,
  output logic             o_dbg_req_n,
  output logic             o_clk_stop_n,
  // bus agent side
  output logic             o_txn_start,
  output logic             o_txn_end,
  output logic             o_snoop_req,
  output logic             o_prio_own
);
  // pins stand until the next command, so they stay valid over any io write
  assign o_bus_restart_n  = ~i_cmd[0];
  assign o_soft_restart_n = ~i_cmd[1];
  assign o_ignore_n       = ~i_cmd[2];
  assign o_lirq_n         = ~i_cmd[4:3];
  assign o_dbg_req_n      = ~i_cmd[5];
  assign o_clk_stop_n     = ~i_cmd[6];
  assign o_txn_start      = i_cmd[7];
  assign o_txn_end        = i_cmd[8];
  assign o_snoop_req      = i_cmd[9];
  // priority agent keeps off the bus while the sequence is locked
  assign o_prio_own       = i_cmd[10] & i_atomic_seq_n;
endmodule
`default_nettype wire

//--- bench/csb_sideband_bench.sv
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAIT_UNTIL(c) begin for (int k = 0; k < 40 && (c) !== 1'b1; k++) begin \
  @(posedge i_clk_sys); #1; end if ((c) !== 1'b1) begin \
  $display("MISMATCH wait exp 1 got %0b", (c)); err_count++; close_out(); end end
module csb_sideband_bench;
  import csb_pkg::*;
  logic        i_clk_sys = 1'b0, i_nrst = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, o_fetch_addr;
  logic [31:0] i_cfg_reset_vector = 32'h0000_1F00;
  logic [1:0]  i_htrans = 2'h0, i_local_irq_lines_n, o_local_irq;
  logic [2:0]  i_hsize = CSB_HSIZE_WORD;
  logic [10:0] cmd = 11'h002;
  logic        o_hreadyout, o_hresp, i_bus_restart_in_n, i_soft_restart_in_n;
  logic        i_ignore_numeric_error_in_n, i_debug_request_in_n, i_clock_stop_request_n;
  logic        o_internal_fault_out_n, o_fp_error_break_event_out_n, o_debug_ready_out_n;
  logic        o_atomic_seq_n, i_bus_txn_start, i_bus_txn_end, i_snoop_req, o_snoop_ack;
  logic        o_shutdown_txn, o_int_regs_reset, o_resume_fetch, o_bist_start;
  logic        o_fp_exception, o_maskable_irq_req, o_nmi_req, prio_own;
  logic [31:0] rd;
  wire logic   i_hready = o_hreadyout;
  int          err_count = 0;
  int          cmp_count = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  csb_sideband i_dut (.i_clk_sys, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp, .i_bus_restart_in_n,
    .i_soft_restart_in_n, .i_ignore_numeric_error_in_n, .i_local_irq_lines_n,
    .i_debug_request_in_n, .i_clock_stop_request_n, .o_internal_fault_out_n,
    .o_fp_error_break_event_out_n, .o_debug_ready_out_n, .o_atomic_seq_n, .i_bus_txn_start,
    .i_bus_txn_end, .i_snoop_req, .o_snoop_ack, .o_shutdown_txn, .i_cfg_reset_vector,
    .o_int_regs_reset, .o_resume_fetch, .o_fetch_addr, .o_bist_start, .o_fp_exception,
    .o_maskable_irq_req, .o_nmi_req, .o_local_irq);

  csb_chipset_model i_far (.i_cmd(cmd), .i_atomic_seq_n(o_atomic_seq_n),
    .o_bus_restart_n(i_bus_restart_in_n), .o_soft_restart_n(i_soft_restart_in_n),
    .o_ignore_n(i_ignore_numeric_error_in_n), .o_lirq_n(i_local_irq_lines_n),
    .o_dbg_req_n(i_debug_request_in_n), .o_clk_stop_n(i_clock_stop_request_n),
    .o_txn_start(i_bus_txn_start), .o_txn_end(i_bus_txn_end), .o_snoop_req(i_snoop_req),
    .o_prio_own(prio_own));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready();
    for (int k = 0; k < 20; k++) begin
      @(posedge i_clk_sys);
      if (i_hready === 1'b1) return;
    end
    $display("MISMATCH hready exp 1 got %0b", i_hready);
    err_count++;
    close_out();
  endtask

  // single word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= wr;
    wait_ready();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready();
    rd = o_hrdata;
  endtask

  // one-cycle pulses are caught by scanning a short window of cycles
  task automatic chk_pulse(input int sel, input logic exp, input string nm);
    logic [4:0] p;
    logic       seen;
    seen = 1'b0;
    repeat (5) begin
      #1;
      p = {o_bist_start, o_resume_fetch, o_int_regs_reset, o_fp_exception, o_shutdown_txn};
      seen = seen | p[sel];
      @(posedge i_clk_sys);
    end
    `CHK(nm, exp, seen)
  endtask

  task automatic sc_reset();
    repeat (12) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    chk_pulse(4, 1'b1, "bist");
    cmd[1] <= 1'b0;
    ahb(1'b0, CSB_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h2, rd)
    // a byte-sized write must be refused and leave the reset value
    i_hsize <= 3'h0;
    ahb(1'b1, CSB_OFS_CTRL, 32'h0);
    i_hsize <= CSB_HSIZE_WORD;
    ahb(1'b0, CSB_OFS_CTRL, 32'h0);
    `CHK("ctrl after byte write", 32'h2, rd)
    ahb(1'b0, CSB_OFS_VECTOR, 32'h0);
    `CHK("vector", i_cfg_reset_vector, rd)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask

  task automatic sc_fault();
    ahb(1'b1, CSB_OFS_EVENT, 32'h1);
    chk_pulse(0, 1'b1, "shutdown");
    `CHK("fault", 1'b0, o_internal_fault_out_n)
    // fault and self-test-ran flags only; everything else idle here
    ahb(1'b0, CSB_OFS_STATUS, 32'h0);
    `CHK("status", 32'h0000_0011, rd)
    repeat (8) @(posedge i_clk_sys);
    `CHK("fault hold", 1'b0, o_internal_fault_out_n)
    cmd[0] <= 1'b1;
    `WAIT_UNTIL(o_internal_fault_out_n)
    `CHK("fault clr", 1'b1, o_internal_fault_out_n)
    @(posedge i_clk_sys);
    cmd[0] <= 1'b0;
    ahb(1'b1, CSB_OFS_EVENT, 32'h1);
    `WAIT_UNTIL(!o_internal_fault_out_n)
    @(posedge i_clk_sys);
    cmd[9] <= 1'b1;
    cmd[1] <= 1'b1;
    chk_pulse(2, 1'b1, "int regs reset");
    `CHK("fault soft clr", 1'b1, o_internal_fault_out_n)
    `CHK("snoop ack", 1'b1, o_snoop_ack)
    cmd[1] <= 1'b0;
    chk_pulse(3, 1'b1, "resume");
    `CHK("fetch addr", i_cfg_reset_vector, o_fetch_addr)
    cmd[9] <= 1'b0;
  endtask

  task automatic sc_fp();
    ahb(1'b1, CSB_OFS_CTRL, 32'h2);
    cmd[2] <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    ahb(1'b1, CSB_OFS_EVENT, 32'h2);
    @(posedge i_clk_sys);
    #1;
    `CHK("fp error pin", 1'b0, o_fp_error_break_event_out_n)
    ahb(1'b1, CSB_OFS_EVENT, 32'h4);
    chk_pulse(1, 1'b0, "fpx ignored");
    cmd[2] <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    ahb(1'b1, CSB_OFS_EVENT, 32'h4);
    chk_pulse(1, 1'b1, "fpx");
    ahb(1'b1, CSB_OFS_CTRL, 32'h3);
    cmd[2] <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    ahb(1'b1, CSB_OFS_EVENT, 32'h2);
    ahb(1'b1, CSB_OFS_EVENT, 32'h4);
    chk_pulse(1, 1'b1, "fpx report bit");
    cmd[2] <= 1'b0;
  endtask

  task automatic sc_irq();
    ahb(1'b1, CSB_OFS_CTRL, 32'h2);
    cmd[3] <= 1'b1;
    `WAIT_UNTIL(o_local_irq == 2'b01)
    `CHK("local irq", 2'b01, o_local_irq)
    ahb(1'b1, CSB_OFS_CTRL, 32'h0);
    `WAIT_UNTIL(o_maskable_irq_req)
    `CHK("maskable", 1'b1, o_maskable_irq_req)
    `CHK("nmi idle", 1'b0, o_nmi_req)
    @(posedge i_clk_sys);
    cmd[4] <= 1'b1;
    `WAIT_UNTIL(o_nmi_req)
    `CHK("nmi", 1'b1, o_nmi_req)
    @(posedge i_clk_sys);
    cmd[4:3] <= 2'b00;
  endtask

  task automatic sc_lock();
    ahb(1'b1, CSB_OFS_CTRL, 32'h4);
    cmd[7] <= 1'b1;
    cmd[10] <= 1'b1;
    @(posedge i_clk_sys);
    cmd[7] <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    `CHK("lock held", 1'b0, o_atomic_seq_n)
    `CHK("prio waits", 1'b0, prio_own)
    ahb(1'b1, CSB_OFS_CTRL, 32'h2);
    cmd[8] <= 1'b1;
    @(posedge i_clk_sys);
    cmd[8] <= 1'b0;
    `WAIT_UNTIL(o_atomic_seq_n)
    `CHK("lock off", 1'b1, o_atomic_seq_n)
    `CHK("prio owns", 1'b1, prio_own)
  endtask

  task automatic sc_debug();
    ahb(1'b1, CSB_OFS_CTRL, 32'hA);
    `WAIT_UNTIL(!o_debug_ready_out_n)
    `CHK("dbg ready", 1'b0, o_debug_ready_out_n)
    @(posedge i_clk_sys);
    cmd[10] <= 1'b0;
    cmd[6] <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    cmd[5] <= 1'b1;
    `WAIT_UNTIL(!o_fp_error_break_event_out_n)
    `CHK("break", 1'b0, o_fp_error_break_event_out_n)
    @(posedge i_clk_sys);
    cmd[5] <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    `CHK("break hold", 1'b0, o_fp_error_break_event_out_n)
    @(posedge i_clk_sys);
    cmd[6] <= 1'b0;
    `WAIT_UNTIL(o_fp_error_break_event_out_n)
    `CHK("break clr", 1'b1, o_fp_error_break_event_out_n)
  endtask

  initial begin
    sc_reset();
    sc_fault();
    sc_fp();
    sc_irq();
    sc_lock();
    sc_debug();
    close_out();
  end
endmodule
`default_nettype wire
